// [ssd_pkg.sv]
package ssd_pkg;

    // Printed register indexes; the APB byte address is four times the index.
    localparam logic [15:0] IDX_CTRL  = 16'h2540;
    localparam logic [15:0] IDX_STAT  = 16'h2541;
    localparam logic [15:0] IDX_DATA  = 16'h2542;
    localparam logic [15:0] IDX_EXT   = 16'h2543;
    localparam logic [15:0] ADDR_CTRL = {IDX_CTRL[13:0], 2'b00};
    localparam logic [15:0] ADDR_STAT = {IDX_STAT[13:0], 2'b00};
    localparam logic [15:0] ADDR_DATA = {IDX_DATA[13:0], 2'b00};
    localparam logic [15:0] ADDR_EXT  = {IDX_EXT[13:0], 2'b00};

    // Control register fields and reset value.
    localparam int unsigned CTRL_IRQ_EN = 7;
    localparam int unsigned CTRL_EN     = 6;
    localparam int unsigned CTRL_CONTROLLER_SELECT   = 4;
    localparam int unsigned CTRL_CLOCK_IDLE_LEVEL   = 3;
    localparam int unsigned CTRL_CLOCK_SAMPLE_PHASE   = 2;
    localparam logic [7:0]  CTRL_RST    = 8'h10;
    localparam logic [7:0]  CTRL_WMASK  = 8'hDF;

    // Status register fields.
    localparam int unsigned STAT_DONE = 7;
    localparam int unsigned STAT_WRITE_COLLISION_FLAG = 6;
    localparam int unsigned STAT_TXF  = 3;
    localparam int unsigned STAT_TXE  = 2;
    localparam int unsigned STAT_RXF  = 1;
    localparam int unsigned STAT_RXE  = 0;

    // Extended register fields and reset values.
    localparam int unsigned EXT_IRQ_BYTE_COUNT_HI = 7;
    localparam int unsigned EXT_IRQ_BYTE_COUNT_LO = 6;
    localparam logic [1:0]  IRQ_BYTE_COUNT_RST    = 2'h0;
    localparam logic [1:0]  RATE_SELECT_HIGH_RST    = 2'h2;

    // Half of each SCK divisor, indexed by the 4-bit selector; reserved codes run slowest.
    localparam int unsigned HALF_W = 12;
    localparam logic [15:0][HALF_W-1:0] HALF_TBL = {
        12'h800, 12'h800, 12'h800, 12'h800, 12'h800, 12'h400, 12'h200, 12'h100,
        12'h080, 12'h040, 12'h008, 12'h020, 12'h010, 12'h004, 12'h800, 12'h800};

    // Shifter counts: sixteen SCK edges make one byte.
    localparam logic [3:0] LAST_EDGE    = 4'hF;
    localparam logic [4:0] TOG_PER_BYTE = 5'h10;
    localparam int unsigned BUF_DEPTH   = 2;

    typedef enum logic {ST_IDLE, ST_SHIFT} ssd_state_e;

endpackage

// [ssd_spi_port.sv]
// How it works
// - Transfer-done flag sets at byte end and holds until software clears it.
// - Writing the data buffer while the transmit queue is full sets write collision.
// - Status bit 3 shows the transmit queue full; resets low.
// - Status bit 2 shows the transmit queue empty; reads one after reset.
// - Status bit 1 shows the receive queue full; resets low.
// - Status bit 0 shows the receive queue empty; reads one after reset.
// - One data address: writes queue a byte, reads return a received byte.
// - Extended bits 7:6 hold the byte count field, reset zero.
// - In counted transfers the done flag sets again after every byte.
// - Divider selector is extended rate bits above control rate bits.
// - Selectors 0010 to 1011 divide by 8,32,64,16,128,256,512,1024,2048,4096.
// - Divider applies in master mode only; slaves take SCK from outside.
// - Idle SCK rests at the clock idle level bit.
// - Equal idle level and phase: change on falling, capture on rising; else opposite.
// - A slave with no queued byte exchanges nothing when clocked.
`timescale 1ns/1ns

module ssd_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic             ref_clk_i,
    input  wire logic             srst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [CW-1:0]               cnt;
    } ssd_fifo_s;

    ssd_fifo_s fifo_reg, fifo_next;
    logic      push, pop;

    // Full and empty come from the count, so neither side can overrun.
    assign in_ready_o  = (fifo_reg.cnt != CW'(DEPTH));
    assign out_valid_o = (fifo_reg.cnt != '0);
    assign out_data_o  = fifo_reg.mem[fifo_reg.rp];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_ready_i & out_valid_o;

    // Pointers wrap explicitly so depths that are not powers of two work.
    always_comb begin
        fifo_next = fifo_reg;
        if (push) begin
            fifo_next.mem[fifo_reg.wp] = in_data_i;
            fifo_next.wp = (fifo_reg.wp == PW'(DEPTH - 1)) ? '0 : fifo_reg.wp + 1'b1;
        end
        if (pop) begin
            fifo_next.rp = (fifo_reg.rp == PW'(DEPTH - 1)) ? '0 : fifo_reg.rp + 1'b1;
        end
        fifo_next.cnt = fifo_reg.cnt + CW'(push) - CW'(pop);
    end

    // State register.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            fifo_reg <= '0;
        end else begin
            fifo_reg <= fifo_next;
        end
    end
endmodule

module ssd_spi_port (
    // Clock and reset.
    input  wire logic        ref_clk_i,
    input  wire logic        srst_i,
    // APB slave.
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [15:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // SPI pins.
    input  wire logic        sck_i,
    output logic             sck_o,
    output logic             sck_oe_n_o,
    input  wire logic        sdi_i,
    output logic             sdo_o,
    output logic             sdo_oe_n_o,
    input  wire logic        ss_n_i
);
    typedef struct packed {
        logic [7:0]                    ctrl;
        logic [1:0]                    irq_byte_count;
        logic [1:0]                    rate_select_high;
        logic                          done;
        logic                          write_collision_flag;
        ssd_pkg::ssd_state_e           state;
        logic [7:0]                    sh;
        logic [3:0]                    edges;
        logic [ssd_pkg::HALF_W-1:0]    div_cnt;
        logic                          sck;
        logic                          sck_prev;
        logic                          sdo;
        logic                          sck_oe_n;
        logic                          sdo_oe_n;
        logic [31:0]                   prdata;
        logic                          pready;
        logic                          pslverr;
        logic [ssd_pkg::HALF_W-1:0]    h_since;
        logic [4:0]                    h_tog;
    } ssd_top_s;
    ssd_top_s                   r, nx;
    logic                       acc_first, acc_done, wr_data, rd_data;
    logic                       hit_ctrl, hit_stat, hit_data, hit_ext;
    logic                       master, clock_idle_level, clock_sample_phase, tick, ev, sample, byte_end, load;
    logic [3:0]                 sel;
    logic [ssd_pkg::HALF_W-1:0] half_w;
    logic                       tx_valid, tx_ready, rx_valid, rx_ready;
    logic [7:0]                 tx_data, rx_data, rx_in, stat_w;
    logic                       tx_full_w, tx_empty_w, rx_full_w, rx_empty_w;

    // APB decode; a transfer gets one wait state so read data comes from a flop.
    assign acc_first = psel_i & penable_i & ~r.pready;
    assign acc_done  = psel_i & penable_i & r.pready;
    assign hit_ctrl  = (paddr_i == ssd_pkg::ADDR_CTRL);
    assign hit_stat  = (paddr_i == ssd_pkg::ADDR_STAT);
    assign hit_data  = (paddr_i == ssd_pkg::ADDR_DATA);
    assign hit_ext   = (paddr_i == ssd_pkg::ADDR_EXT);
    assign wr_data   = acc_done & pwrite_i & hit_data;
    assign rd_data   = acc_done & ~pwrite_i & hit_data;

    // Mode and rate selection.
    assign master = r.ctrl[ssd_pkg::CTRL_CONTROLLER_SELECT];
    assign clock_idle_level   = r.ctrl[ssd_pkg::CTRL_CLOCK_IDLE_LEVEL];
    assign clock_sample_phase   = r.ctrl[ssd_pkg::CTRL_CLOCK_SAMPLE_PHASE];
    assign sel    = {r.rate_select_high, r.ctrl[1:0]};
    assign half_w = ssd_pkg::HALF_TBL[sel];

    // Bit timing: edges count from zero, even ones lead; the slave follows SCK only.
    assign tick     = master & (r.state == ssd_pkg::ST_SHIFT) & (r.div_cnt == half_w - 1'b1);
    assign ev       = tick | (~master & ~ss_n_i & (r.state == ssd_pkg::ST_SHIFT)
                              & (sck_i != r.sck_prev));
    assign sample   = ~r.edges[0] ^ clock_sample_phase;
    assign byte_end = ev & (r.edges == ssd_pkg::LAST_EDGE);
    assign load     = r.ctrl[ssd_pkg::CTRL_EN] & (r.state == ssd_pkg::ST_IDLE)
                      & tx_valid & rx_ready;
    assign rx_in    = clock_sample_phase ? {r.sh[6:0], sdi_i} : r.sh;

    // Queue flags.
    assign tx_full_w  = ~tx_ready;
    assign tx_empty_w = ~tx_valid;
    assign rx_full_w  = ~rx_ready;
    assign rx_empty_w = ~rx_valid;
    assign stat_w     = {r.done, r.write_collision_flag, 2'b00, tx_full_w, tx_empty_w, rx_full_w, rx_empty_w};

    // Transmit queue; a full queue refuses the byte and raises the collision flag.
    ssd_fifo #(.WIDTH(8), .DEPTH(ssd_pkg::BUF_DEPTH)) u_tx_queue (
        .ref_clk_i   (ref_clk_i),
        .srst_i      (srst_i),
        .in_valid_i  (wr_data),
        .in_ready_o  (tx_ready),
        .in_data_i   (pwdata_i[7:0]),
        .out_valid_o (tx_valid),
        .out_ready_i (load),
        .out_data_o  (tx_data)
    );

    // Receive queue; when it is full no new byte starts, so no reply is lost.
    ssd_fifo #(.WIDTH(8), .DEPTH(ssd_pkg::BUF_DEPTH)) u_rx_queue (
        .ref_clk_i   (ref_clk_i),
        .srst_i      (srst_i),
        .in_valid_i  (byte_end),
        .in_ready_o  (rx_ready),
        .in_data_i   (rx_in),
        .out_valid_o (rx_valid),
        .out_ready_i (rd_data),
        .out_data_o  (rx_data)
    );

    // Next-state logic for registers, bus answer and shifter.
    always_comb begin
        nx          = r;
        nx.sck_prev = sck_i;
        nx.pready   = acc_first;
        nx.pslverr  = acc_first & ~(hit_ctrl | hit_stat | hit_data | hit_ext);
        if (acc_first & ~pwrite_i) begin
            nx.prdata = '0;
            if (hit_ctrl) nx.prdata[7:0] = r.ctrl;
            if (hit_stat) nx.prdata[7:0] = stat_w;
            if (hit_data) nx.prdata[7:0] = rx_data;
            if (hit_ext) nx.prdata[7:0] = {r.irq_byte_count, 4'h0, r.rate_select_high};
        end
        if (acc_done & pwrite_i & hit_ctrl) begin
            nx.ctrl = pwdata_i[7:0] & ssd_pkg::CTRL_WMASK;
        end
        if (acc_done & pwrite_i & hit_ext) begin
            nx.irq_byte_count = pwdata_i[ssd_pkg::EXT_IRQ_BYTE_COUNT_HI:ssd_pkg::EXT_IRQ_BYTE_COUNT_LO];
            nx.rate_select_high = pwdata_i[1:0];
        end
        // Writing zero clears a flag, but a new event in the same cycle wins.
        if (acc_done & pwrite_i & hit_stat) begin
            nx.done = r.done & pwdata_i[ssd_pkg::STAT_DONE];
            nx.write_collision_flag = r.write_collision_flag & pwdata_i[ssd_pkg::STAT_WRITE_COLLISION_FLAG];
        end
        if (wr_data & tx_full_w) nx.write_collision_flag = 1'b1;
        if (byte_end) nx.done = 1'b1;
        // Shifter.
        case (r.state)
            ssd_pkg::ST_IDLE: begin
                nx.sck     = clock_idle_level;
                nx.div_cnt = '0;
                if (load) begin
                    nx.sh    = tx_data;
                    nx.sdo   = tx_data[7];
                    nx.edges = '0;
                    nx.state = ssd_pkg::ST_SHIFT;
                end
            end
            ssd_pkg::ST_SHIFT: begin
                nx.div_cnt = tick ? '0 : r.div_cnt + 1'b1;
                if (ev) begin
                    nx.edges = r.edges + 4'h1;
                    if (master) nx.sck = ~r.sck;
                    if (sample) nx.sh = {r.sh[6:0], sdi_i};
                    else nx.sdo = r.sh[7];
                end
                if (byte_end) nx.state = ssd_pkg::ST_IDLE;
            end
            default: nx.state = ssd_pkg::ST_IDLE;
        endcase
        // Pin enables; a slave drives data only while selected.
        nx.sck_oe_n = ~(r.ctrl[ssd_pkg::CTRL_EN] & master);
        nx.sdo_oe_n = ~(r.ctrl[ssd_pkg::CTRL_EN] & (master | ~ss_n_i));
        // Helpers watched only by the checks below.
        nx.h_since = (nx.sck != r.sck) ? '0 : r.h_since + 1'b1;
        if (load) nx.h_tog = '0;
        else if (nx.sck != r.sck) nx.h_tog = r.h_tog + 5'h01;
    end

    // State register; reset leaves the port as a master that is switched off.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            r          <= '0;
            r.ctrl     <= ssd_pkg::CTRL_RST;
            r.irq_byte_count     <= ssd_pkg::IRQ_BYTE_COUNT_RST;
            r.rate_select_high     <= ssd_pkg::RATE_SELECT_HIGH_RST;
            r.state    <= ssd_pkg::ST_IDLE;
            r.sck_oe_n <= 1'b1;
            r.sdo_oe_n <= 1'b1;
        end else begin
            r <= nx;
        end
    end

    assign prdata_o   = r.prdata;
    assign pready_o   = r.pready;
    assign pslverr_o  = r.pslverr;
    assign sck_o      = r.sck;
    assign sck_oe_n_o = r.sck_oe_n;
    assign sdo_o      = r.sdo;
    assign sdo_oe_n_o = r.sdo_oe_n;

    // Checks.
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    property p_done_set;
        byte_end |=> r.done;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag missed a byte end");
    property p_done_hold;
        r.done && !(acc_done && pwrite_i && hit_stat) |=> r.done;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("done flag dropped alone");
    // A load in the same cycle frees a slot, so the queue need not stay full then.
    property p_write_collision_flag;
        wr_data && tx_full_w && !load |=> r.write_collision_flag && tx_full_w;
    endproperty
    a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision flag not set");
    property p_stat_full;
        acc_first && !pwrite_i && hit_stat |=>
            prdata_o[ssd_pkg::STAT_TXF] == $past(tx_full_w)
            && prdata_o[ssd_pkg::STAT_RXF] == $past(rx_full_w);
    endproperty
    a_stat_full: assert property (p_stat_full) else $error("full flags misread");
    property p_stat_empty;
        acc_first && !pwrite_i && hit_stat |=>
            prdata_o[ssd_pkg::STAT_TXE] == $past(tx_empty_w)
            && prdata_o[ssd_pkg::STAT_RXE] == $past(rx_empty_w);
    endproperty
    a_stat_empty: assert property (p_stat_empty) else $error("empty flags misread");
    property p_rst_empty;
        $fell(srst_i) |-> tx_empty_w && rx_empty_w && !tx_full_w && !rx_full_w;
    endproperty
    a_rst_empty: assert property (p_rst_empty) else $error("queue flags wrong after reset");
    property p_data_queue;
        wr_data && !tx_full_w |=> !tx_empty_w || r.state == ssd_pkg::ST_SHIFT;
    endproperty
    a_data_queue: assert property (p_data_queue) else $error("written byte not queued");
    property p_ext_read;
        acc_first && !pwrite_i && hit_ext |=> prdata_o[7:6] == r.irq_byte_count && pready_o;
    endproperty
    a_ext_read: assert property (p_ext_read) else $error("byte count misread");
    property p_rate;
        master && $changed(r.sck) && r.state == ssd_pkg::ST_SHIFT && r.edges > 4'h1
            |-> $past(r.h_since) == half_w - 1'b1;
    endproperty
    a_rate: assert property (p_rate) else $error("SCK half period wrong");
    property p_slave_oe;
        !master ##1 !master |-> sck_oe_n_o;
    endproperty
    a_slave_oe: assert property (p_slave_oe) else $error("slave drives SCK");
    property p_eight;
        byte_end && master |=> r.h_tog == ssd_pkg::TOG_PER_BYTE && r.state == ssd_pkg::ST_IDLE;
    endproperty
    a_eight: assert property (p_eight) else $error("byte did not take eight SCK cycles");
    property p_idle_level;
        r.state == ssd_pkg::ST_IDLE ##1 r.state == ssd_pkg::ST_IDLE && $stable(clock_idle_level)
            |-> sck_o == clock_idle_level;
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("idle SCK level wrong");
    property p_no_xfer;
        !master && r.state == ssd_pkg::ST_IDLE && tx_empty_w |=> !byte_end;
    endproperty
    a_no_xfer: assert property (p_no_xfer) else $error("slave exchanged without data");
    c_master_byte: cover property (byte_end && master);
    c_slave_byte: cover property (byte_end && !master);
    c_collision: cover property (wr_data && tx_full_w);
endmodule

// [ssd_peer_model.sv]
`timescale 1ns/1ns

// Far-side slave for master traffic: a plain exchange register that echoes the last byte.
module ssd_peer_model (
    // Line side.
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    output logic            miso_o,
    // Bench side.
    input  wire logic       arm_i,
    input  wire logic       clock_idle_level_i,
    input  wire logic       clock_sample_phase_i,
    input  wire logic [7:0] reply_i,
    output logic      [7:0] got_o
);
    logic [7:0] sh = 8'h00;
    logic [7:0] rx = 8'h00;
    int         cnt = 0;

    // Arming loads the first reply and restarts the edge count.
    always @(posedge arm_i) begin
        sh = reply_i;
        cnt = 0;
    end

    // A disarmed peer has let go, so the line shows the inverse of its last bit.
    assign miso_o = arm_i ? sh[7] : ~sh[7];

    // An edge leaving the idle level is leading; idle changes are ignored while disarmed.
    always @(sck_i) begin
        if (arm_i) begin
            if ((sck_i !== clock_idle_level_i) ^ clock_sample_phase_i) begin
                rx = {rx[6:0], mosi_i};
            end else if (!(clock_sample_phase_i && cnt == 0)) begin
                sh = {sh[6:0], 1'b0};
            end
            cnt = cnt + 1;
            if (cnt == 16) begin
                got_o = rx;
                sh = rx;
                cnt = 0;
            end
        end
    end
endmodule

// [tb_ssd_spi_port.sv]
`timescale 1ns/1ns

module tb_ssd_spi_port;
    logic        clk;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    wire  [31:0] prdata;
    wire         pready, pslverr, sck_o, sck_oe_n, sdo, sdo_oe_n, miso;
    logic        tb_sck = 1'b0;
    logic        ss_n = 1'b1;
    logic        arm = 1'b0;
    logic        clock_idle_level = 1'b0;
    logic        clock_sample_phase = 1'b0;
    logic [7:0]  reply = 8'h00;
    wire  [7:0]  got;
    int          err_total = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          n;
    logic [15:0] seed = 16'hB5B5;
    logic [7:0]  rd, t1, t2;
    logic        e, s;

    // The shared clock line is whoever's enable is low; the bench drives it otherwise.
    wire sck_w = sck_oe_n ? tb_sck : sck_o;

    ssd_spi_port uut (.ref_clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .sck_i(sck_w), .sck_o(sck_o),
        .sck_oe_n_o(sck_oe_n), .sdi_i(miso), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .ss_n_i(ss_n));

    ssd_peer_model peer (.sck_i(sck_w), .mosi_i(sdo), .miso_o(miso), .arm_i(arm),
        .clock_idle_level_i(clock_idle_level), .clock_sample_phase_i(clock_sample_phase), .reply_i(reply), .got_o(got));

    // Clock at 20 MHz.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    // Half divisor per selector; the odd ordering of the low codes is intended.
    function automatic int half_of(input logic [3:0] c);
        case (c)
            4'h2: return 4;
            4'h3: return 16;
            4'h4: return 32;
            4'h5: return 8;
            default: return 64 << (c - 4'h6);
        endcase
    endfunction

    task automatic nxt(output logic [7:0] b);
        seed = lfsr(seed);
        b = seed[7:0];
    endtask

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, x, g);
        end
    endtask

    // One APB transfer; the request stands until pready is seen at a rising edge.
    task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d,
                       output logic [7:0] r, output logic er);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        // Only the global cycle limit ends a wait for the answer.
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic       er;
        apb(1'b1, a, d, r, er);
    endtask

    task automatic rc(input string nm, input logic [15:0] a, input logic [7:0] x);
        logic [7:0] r;
        logic       er;
        apb(1'b0, a, 8'h00, r, er);
        chk(nm, {24'h00_0000, x}, {24'h00_0000, r});
    endtask

    // Polling is bounded; the global cycle limit catches anything longer.
    task automatic wait_stat(input logic [7:0] m);
        logic [7:0] r;
        logic       er;
        int         k;
        r = 8'h00;
        k = 0;
        while ((r & m) == 8'h00 && k < 20000) begin
            apb(1'b0, ssd_pkg::ADDR_STAT, 8'h00, r, er);
            k++;
        end
    endtask

    task automatic clk16();
        repeat (16) begin
            tb_sck <= ~tb_sck;
            repeat (4) @(posedge clk);
        end
    endtask

    task automatic tend(input string nm);
        $display("test %s finished", nm);
    endtask

    task automatic final_report();
        $display("counts: %0d compared, %0d bad", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Cycle limit sized for the slowest divisor sweep with margin.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            err_total++;
            final_report();
        end
    end

    // Main sequence.
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rc("ctrl", ssd_pkg::ADDR_CTRL, 8'h10);
        rc("stat", ssd_pkg::ADDR_STAT, 8'h05);
        rc("ext", ssd_pkg::ADDR_EXT, 8'h02);
        apb(1'b0, 16'h9510, 8'h00, rd, e);
        chk("slverr", 32'(1), 32'(e));
        wr(ssd_pkg::ADDR_EXT, 8'hFF);
        rc("ext", ssd_pkg::ADDR_EXT, 8'hC3);
        tend("registers");
        // Disabled port: fill the transmit queue until it refuses a byte.
        nxt(t1);
        nxt(t2);
        wr(ssd_pkg::ADDR_DATA, t1);
        rc("stat", ssd_pkg::ADDR_STAT, 8'h01);
        wr(ssd_pkg::ADDR_DATA, t2);
        rc("stat", ssd_pkg::ADDR_STAT, 8'h09);
        wr(ssd_pkg::ADDR_DATA, 8'hA5);
        rc("stat", ssd_pkg::ADDR_STAT, 8'h49);
        wr(ssd_pkg::ADDR_STAT, 8'h00);
        rc("stat", ssd_pkg::ADDR_STAT, 8'h09);
        // Two queued bytes go out back to back while software leaves the reply unread.
        wr(ssd_pkg::ADDR_EXT, 8'h00);
        nxt(rd);
        reply <= rd;
        arm <= 1'b1;
        wr(ssd_pkg::ADDR_CTRL, 8'h52);
        wait_stat(8'h80);
        wr(ssd_pkg::ADDR_STAT, 8'h00);
        rc("stat", ssd_pkg::ADDR_STAT, 8'h04);
        wait_stat(8'h80);
        rc("stat", ssd_pkg::ADDR_STAT, 8'h86);
        chk("peer", 32'(t2), 32'(got));
        rc("data", ssd_pkg::ADDR_DATA, rd);
        rc("data", ssd_pkg::ADDR_DATA, t1);
        rc("stat", ssd_pkg::ADDR_STAT, 8'h85);
        arm <= 1'b0;
        tend("queues");
        // Every valid selector, cycling through all four clock modes.
        for (logic [3:0] c = 4'h2; c != 4'hC; c++) begin
            clock_idle_level <= c[1];
            clock_sample_phase <= c[0];
            wr(ssd_pkg::ADDR_STAT, 8'h00);
            wr(ssd_pkg::ADDR_EXT, {6'h00, c[3:2]});
            wr(ssd_pkg::ADDR_CTRL, {4'h5, c[1], c[0], c[1:0]});
            repeat (2) @(posedge clk);
            chk("idle", 32'(c[1]), 32'(sck_o));
            nxt(rd);
            reply <= rd;
            arm <= 1'b1;
            nxt(t1);
            wr(ssd_pkg::ADDR_DATA, t1);
            s = sck_o;
            n = 0;
            while (sck_o === s && n < 9000) begin
                @(posedge clk);
                n++;
            end
            s = sck_o;
            n = 0;
            while (sck_o === s && n < 9000) begin
                @(posedge clk);
                n++;
            end
            chk("half", 32'(half_of(c)), 32'(n));
            wait_stat(8'h80);
            chk("peer", 32'(t1), 32'(got));
            rc("data", ssd_pkg::ADDR_DATA, rd);
            arm <= 1'b0;
        end
        tend("divider");
        // Slave mode: clocks without a queued byte must exchange nothing.
        wr(ssd_pkg::ADDR_STAT, 8'h00);
        wr(ssd_pkg::ADDR_CTRL, 8'h40);
        ss_n <= 1'b0;
        clk16();
        ss_n <= 1'b1;
        rc("stat", ssd_pkg::ADDR_STAT, 8'h05);
        nxt(t1);
        wr(ssd_pkg::ADDR_DATA, t1);
        // The peer now acts as the far master's data end, in mode zero like the port.
        clock_idle_level <= 1'b0;
        clock_sample_phase <= 1'b0;
        nxt(rd);
        reply <= rd;
        arm <= 1'b1;
        ss_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk("sdo_oe_n", 32'(0), 32'(sdo_oe_n));
        chk("sck_oe_n", 32'(1), 32'(sck_oe_n));
        clk16();
        ss_n <= 1'b1;
        rc("stat", ssd_pkg::ADDR_STAT, 8'h84);
        chk("slave peer", 32'(t1), 32'(got));
        rc("slave data", ssd_pkg::ADDR_DATA, rd);
        arm <= 1'b0;
        tend("slave");
        final_report();
    end
endmodule
